// ---- rtl/sfd_map.svh ----
// Opcodes, lengths and sizes of the serial flash command decoder
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// ============================================================
// Opcodes
`define SFD_OP_ECC_READ        8'h19
`define SFD_OP_ECC_CLEAR       8'h1B
`define SFD_OP_RANGE_CHECK     8'h5B
`define SFD_OP_NORM_READ       8'h03
`define SFD_OP_NORM_READ_WIDE  8'h13
`define SFD_OP_FAST_READ       8'h0B
`define SFD_OP_PAGE_PROG       8'h12
`define SFD_OP_SMALL_ERASE     8'h21
`define SFD_OP_LARGE_ERASE     8'hDC
`define SFD_OP_CHIP_ERASE_A    8'h60
`define SFD_OP_CHIP_ERASE_B    8'hC7
`define SFD_OP_ERASE_CHECK     8'hD0
`define SFD_OP_ERASE_COUNT     8'h5D
`define SFD_OP_WRITE_LATCH_SET 8'h06
`define SFD_OP_ADDR4_ENTER     8'hB7
`define SFD_OP_ADDR4_EXIT      8'hB8

// ============================================================
// Address byte counts
`define SFD_LEN_NONE  4'h0
`define SFD_LEN_SHORT 4'h3
`define SFD_LEN_WIDE  4'h4
`define SFD_LEN_RANGE 4'h8

// ============================================================
// Reset values, sizes and host clock limits in MHz
`define SFD_ADDR4_RESET        1'b0
`define SFD_FIFO_DEPTH         32
`define SFD_FIFO_WIDTH         8
`define SFD_NORMAL_READ_MAX_MHZ 50
`define SFD_FAST_READ_MAX_MHZ   166

`endif

// ---- rtl/sfd_pkg.sv ----
// Types of the serial flash command decoder
package sfd_pkg;

  // ============================================================
  // Command kinds handed to the array controller
  typedef enum logic [3:0] {
    SFD_K_NONE,
    SFD_K_ECC_READ,
    SFD_K_ECC_CLEAR,
    SFD_K_RANGE_CHECK,
    SFD_K_NORM_READ,
    SFD_K_FAST_READ,
    SFD_K_PAGE_PROG,
    SFD_K_SMALL_ERASE,
    SFD_K_LARGE_ERASE,
    SFD_K_CHIP_ERASE,
    SFD_K_ERASE_CHECK,
    SFD_K_ERASE_COUNT
  } sfd_kind_t;

  // ============================================================
  // Decoder states
  typedef enum logic [2:0] {
    SFD_S_OPCODE,
    SFD_S_ADDR,
    SFD_S_DATA,
    SFD_S_RESP,
    SFD_S_HOLD,
    SFD_S_DROP
  } sfd_state_t;

  // ============================================================
  // Decoded command
  typedef struct packed {
    sfd_kind_t   kind;
    logic        wide;
    logic [31:0] addr;
    logic [31:0] end_addr;
  } sfd_cmd_t;

endpackage

// ---- rtl/sfd_fifo.sv ----
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps

module sfd_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input  logic             clk_i,
  input  logic             rst_i,
  input  logic             in_valid_i,
  output logic             in_ready_o,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             out_valid_o,
  input  logic             out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // ============================================================
  // Fill state
  wire mem_empty = (wr_ptr == rd_ptr);
  wire mem_full  = (wr_ptr[AW] != rd_ptr[AW])
                && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire do_push   = in_valid_i && !mem_full;
  wire do_load   = !mem_empty && (!out_valid_o || out_ready_i);

  assign in_ready_o = !mem_full;

  // Storage write
  always_ff @(posedge clk_i)
    if (do_push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;

  // Write pointer
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      wr_ptr <= '0;
    else if (do_push)
      wr_ptr <= wr_ptr + 1'b1;

  // Output stage and read pointer
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rd_ptr      <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else if (do_load)
    begin
      rd_ptr      <= rd_ptr + 1'b1;
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr[AW-1:0]];
    end
    else if (out_ready_i)
      out_valid_o <= 1'b0;

endmodule

// ---- rtl/sfd_decode.sv ----
// Serial flash command decoder with link front end and program FIFO
`timescale 1ns/1ps
`include "sfd_map.svh"
// ============================================================
// Overview of operation
// - Opcode 19 plus four address bytes requests ECC status of a unit.
// - Opcode 1B alone clears ECC status bits, address trap and counter.
// - Opcode 5B takes start then end address, four bytes each.
// - Opcode 03 uses three or four address bytes; 13 always four.
// - Opcode 0B fast read with three or four address bytes.
// - Opcode 12 with four address bytes streams page data bytes.
// - Opcode 21 with four address bytes erases a 4 KB sector.
// - Opcode DC with four address bytes erases a 256 KB sector.
// - Opcode 60 or C7 alone erases the whole array.
// - Opcode D0 with four address bytes checks last sector erase.
// - Opcode 5D with four address bytes reads sector erase count.
// - Opcode 06 sets write latch; program and erase need it.
// - Opcode B7 selects four-byte addresses for 03 and 0B, B8 three-byte addresses.

module sfd_decode
  import sfd_pkg::*;
#(
  parameter int FIFO_DEPTH = `SFD_FIFO_DEPTH
)
(
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       serial_clock_i,
  input  logic       cs_n_i,
  input  logic       mosi_i,
  output logic       miso_o,
  output logic       miso_oe_o,
  output logic       cmd_valid_o,
  output sfd_cmd_t   cmd_o,
  output logic       cmd_drop_o,
  output logic       frame_end_o,
  output logic       wel_o,
  output logic       addr4_o,
  output logic       prog_valid_o,
  output logic [7:0] prog_data_o,
  input  logic       prog_ready_i,
  output logic       prog_overflow_o,
  output logic       rsp_req_o,
  input  logic       rsp_valid_i,
  input  logic [7:0] rsp_data_i
);

  // ============================================================
  // Link side: byte assembly on the serial clock
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] rx_byte;
  logic       rx_tog;
  logic [7:0] tx_shift;
  logic       rsp_meta;
  logic       rsp_sync;
  logic       rsp_seen;
  logic [7:0] rsp_byte;
  logic       rsp_tog;

  // Bit counter, cleared whenever the device is deselected
  always_ff @(posedge serial_clock_i or posedge cs_n_i)
    if (cs_n_i)
    begin
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
    end
    else
    begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= {shift_in[5:0], mosi_i};
    end

  // Completed byte and its toggle, kept across frames
  always_ff @(posedge serial_clock_i or posedge rst_i)
    if (rst_i)
    begin
      rx_byte <= 8'h00;
      rx_tog  <= 1'b0;
    end
    else if (bit_cnt == 3'h7)
    begin
      rx_byte <= {shift_in, mosi_i};
      rx_tog  <= ~rx_tog;
    end

  // Response toggle synchroniser on the falling edge
  wire tx_load = (bit_cnt == 3'h0) && (rsp_sync != rsp_seen);

  always_ff @(negedge serial_clock_i or posedge rst_i)
    if (rst_i)
    begin
      rsp_meta <= 1'b0;
      rsp_sync <= 1'b0;
      rsp_seen <= 1'b0;
    end
    else
    begin
      rsp_meta <= rsp_tog;
      rsp_sync <= rsp_meta;
      if (tx_load)
        rsp_seen <= rsp_sync;
    end

  // Output shifter, most significant bit first
  always_ff @(negedge serial_clock_i or posedge cs_n_i)
    if (cs_n_i)
    begin
      tx_shift  <= 8'h00;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_shift  <= {rsp_byte[6:0], 1'b0};
      miso_o    <= rsp_byte[7];
      miso_oe_o <= 1'b1;
    end
    else
    begin
      tx_shift <= {tx_shift[6:0], 1'b0};
      miso_o   <= tx_shift[7];
    end

  // ============================================================
  // Core side: crossings into the system clock
  logic rx_meta;
  logic rx_sync;
  logic rx_last;
  logic cs_meta;
  logic cs_sync;
  logic cs_last;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_last <= 1'b0;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_last <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_tog;
      rx_sync <= rx_meta;
      rx_last <= rx_sync;
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
    end

  wire byte_evt  = rx_sync ^ rx_last;
  wire frame_end = cs_sync & ~cs_last;
  wire ev        = byte_evt && !frame_end;

  // Response byte handed to the link side by toggle
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rsp_byte <= 8'h00;
      rsp_tog  <= 1'b0;
    end
    else if (rsp_valid_i)
    begin
      rsp_byte <= rsp_data_i;
      rsp_tog  <= ~rsp_tog;
    end

  // ============================================================
  // Opcode decode
  sfd_state_t  state;
  logic [3:0]  addr_cnt;
  logic [63:0] addr_sh;
  sfd_kind_t   cur_kind;
  logic        cur_wide;
  logic        wel_arm;

  wire [7:0] op = rx_byte;
  sfd_kind_t op_kind;
  assign op_kind =
    (op == `SFD_OP_ECC_READ)       ? SFD_K_ECC_READ    :
    (op == `SFD_OP_ECC_CLEAR)      ? SFD_K_ECC_CLEAR   :
    (op == `SFD_OP_RANGE_CHECK)    ? SFD_K_RANGE_CHECK :
    (op == `SFD_OP_NORM_READ)      ? SFD_K_NORM_READ   :
    (op == `SFD_OP_NORM_READ_WIDE) ? SFD_K_NORM_READ   :
    (op == `SFD_OP_FAST_READ)      ? SFD_K_FAST_READ   :
    (op == `SFD_OP_PAGE_PROG)      ? SFD_K_PAGE_PROG   :
    (op == `SFD_OP_SMALL_ERASE)    ? SFD_K_SMALL_ERASE :
    (op == `SFD_OP_LARGE_ERASE)    ? SFD_K_LARGE_ERASE :
    (op == `SFD_OP_CHIP_ERASE_A)   ? SFD_K_CHIP_ERASE  :
    (op == `SFD_OP_CHIP_ERASE_B)   ? SFD_K_CHIP_ERASE  :
    (op == `SFD_OP_ERASE_CHECK)    ? SFD_K_ERASE_CHECK :
    (op == `SFD_OP_ERASE_COUNT)    ? SFD_K_ERASE_COUNT :
                                     SFD_K_NONE;

  // Address length: mode-dependent only for 03 and 0B
  wire op_var    = (op == `SFD_OP_NORM_READ) || (op == `SFD_OP_FAST_READ);
  wire op_bare   = (op_kind == SFD_K_ECC_CLEAR)
                || (op_kind == SFD_K_CHIP_ERASE);
  wire [3:0] op_len =
    op_bare                        ? `SFD_LEN_NONE  :
    (op_kind == SFD_K_RANGE_CHECK) ? `SFD_LEN_RANGE :
    (op_var && !addr4_o)           ? `SFD_LEN_SHORT :
                                     `SFD_LEN_WIDE;
  wire op_write  = (op_kind == SFD_K_PAGE_PROG)
                || (op_kind == SFD_K_SMALL_ERASE)
                || (op_kind == SFD_K_LARGE_ERASE)
                || (op_kind == SFD_K_CHIP_ERASE);
  wire op_local  = (op == `SFD_OP_WRITE_LATCH_SET)
                || (op == `SFD_OP_ADDR4_ENTER)
                || (op == `SFD_OP_ADDR4_EXIT);
  wire cur_reads = (cur_kind == SFD_K_ECC_READ)
                || (cur_kind == SFD_K_NORM_READ)
                || (cur_kind == SFD_K_FAST_READ)
                || (cur_kind == SFD_K_ERASE_COUNT);

  // Strobes of the current byte
  wire in_op    = ev && (state == SFD_S_OPCODE);
  wire in_addr  = ev && (state == SFD_S_ADDR);
  wire addr_end = in_addr && (addr_cnt == 4'h1);
  wire refuse   = in_op && op_write && !wel_o;
  wire [63:0] next_sh = {addr_sh[55:0], rx_byte};

  // Command assembled from the final address byte
  sfd_cmd_t next_cmd;
  assign next_cmd.kind     = cur_kind;
  assign next_cmd.wide     = cur_wide;
  assign next_cmd.addr     =
    (cur_kind == SFD_K_RANGE_CHECK) ? next_sh[63:32] :
    cur_wide ? next_sh[31:0] : {8'h00, next_sh[23:0]};
  assign next_cmd.end_addr =
    (cur_kind == SFD_K_RANGE_CHECK) ? next_sh[31:0] : 32'h0000_0000;

  sfd_cmd_t bare_cmd;
  assign bare_cmd = '{kind: op_kind, wide: 1'b0,
                      addr: 32'h0000_0000, end_addr: 32'h0000_0000};

  // ============================================================
  // Transaction sequencer
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      state    <= SFD_S_OPCODE;
      addr_cnt <= 4'h0;
      addr_sh  <= 64'h0;
      cur_kind <= SFD_K_NONE;
      cur_wide <= 1'b0;
    end
    else if (frame_end)
      state <= SFD_S_OPCODE;
    else if (in_op)
    begin
      cur_kind <= op_kind;
      cur_wide <= (op_len == `SFD_LEN_WIDE);
      addr_cnt <= op_len;
      addr_sh  <= 64'h0;
      if (op_local)
        state <= SFD_S_HOLD;
      else if ((op_kind == SFD_K_NONE) || refuse)
        state <= SFD_S_DROP;
      else if (op_len == `SFD_LEN_NONE)
        state <= SFD_S_HOLD;
      else
        state <= SFD_S_ADDR;
    end
    else if (in_addr)
    begin
      addr_sh  <= next_sh;
      addr_cnt <= addr_cnt - 4'h1;
      if (addr_end && (cur_kind == SFD_K_PAGE_PROG))
        state <= SFD_S_DATA;
      else if (addr_end && cur_reads)
        state <= SFD_S_RESP;
      else if (addr_end)
        state <= SFD_S_HOLD;
    end

  // Command strobe and refusal strobe
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
      cmd_drop_o  <= 1'b0;
      frame_end_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= addr_end || (in_op && op_bare && !refuse);
      cmd_drop_o  <= refuse;
      frame_end_o <= frame_end;
      if (addr_end)
        cmd_o <= next_cmd;
      else if (in_op && op_bare)
        cmd_o <= bare_cmd;
    end

  // Response requests: one after the address, one per byte sent
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rsp_req_o <= 1'b0;
    else
      rsp_req_o <= (addr_end && cur_reads)
                || (ev && (state == SFD_S_RESP));

  // ============================================================
  // Write latch and address length mode
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      wel_o   <= 1'b0;
      wel_arm <= 1'b0;
      addr4_o <= `SFD_ADDR4_RESET;
    end
    else
    begin
      if (frame_end)
        wel_arm <= 1'b0;
      else if (in_op && op_write && wel_o)
        wel_arm <= 1'b1;
      if (frame_end && wel_arm)
        wel_o <= 1'b0;
      else if (in_op && (op == `SFD_OP_WRITE_LATCH_SET))
        wel_o <= 1'b1;
      if (in_op && (op == `SFD_OP_ADDR4_ENTER))
        addr4_o <= 1'b1;
      else if (in_op && (op == `SFD_OP_ADDR4_EXIT))
        addr4_o <= 1'b0;
    end

  // ============================================================
  // Program data path
  logic fifo_in_ready;
  wire  push = ev && (state == SFD_S_DATA);

  sfd_fifo #(
    .WIDTH (`SFD_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) sfd_fifo_i (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_byte),
    .out_valid_o (prog_valid_o),
    .out_ready_i (prog_ready_i),
    .out_data_o  (prog_data_o)
  );

  // Overflow is sticky until the next opcode; a new loss wins
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      prog_overflow_o <= 1'b0;
    else if (push && !fifo_in_ready)
      prog_overflow_o <= 1'b1;
    else if (in_op)
      prog_overflow_o <= 1'b0;

  // ============================================================
  // Checks
  logic [3:0] byte_idx;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      byte_idx <= 4'h0;
    else if (frame_end)
      byte_idx <= 4'h0;
    else if (ev && (byte_idx != 4'hF))
      byte_idx <= byte_idx + 4'h1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_op(logic [7:0] b);
    (state == SFD_S_OPCODE) && ev && (rx_byte == b);
  endsequence

  sequence s_cmd(sfd_kind_t k);
    cmd_valid_o && (cmd_o.kind == k);
  endsequence

  a_ecc_clear_bare: assert property (
    s_op(`SFD_OP_ECC_CLEAR) |=> s_cmd(SFD_K_ECC_CLEAR) ##0 (byte_idx == 4'h1))
    else $error("ecc clear not issued at once");
  a_range_two_addr: assert property (
    s_cmd(SFD_K_RANGE_CHECK) |-> (byte_idx == 4'h9))
    else $error("range check byte count wrong");
  a_wide_addr_len: assert property (
    cmd_valid_o && cmd_o.wide |-> (byte_idx == 4'h5))
    else $error("four byte command count wrong");
  a_mode_addr_len: assert property (
    cmd_valid_o && !cmd_o.wide && (cmd_o.kind != SFD_K_RANGE_CHECK)
      && (cmd_o.kind != SFD_K_ECC_CLEAR) && (cmd_o.kind != SFD_K_CHIP_ERASE)
      |-> (byte_idx == 4'h4) && !addr4_o)
    else $error("three byte read count wrong");
  a_chip_erase_go: assert property (
    s_op(`SFD_OP_CHIP_ERASE_B) ##0 wel_o[*1] |=> s_cmd(SFD_K_CHIP_ERASE))
    else $error("chip erase not issued");
  a_latch_set: assert property (
    s_op(`SFD_OP_WRITE_LATCH_SET) |=> wel_o ##1 wel_o)
    else $error("write latch not set");
  a_latch_spent: assert property (
    frame_end && wel_arm |=> !wel_o && (state == SFD_S_OPCODE))
    else $error("write latch kept after write");
  a_addr_enter: assert property (
    s_op(`SFD_OP_ADDR4_ENTER) |=> addr4_o)
    else $error("four byte mode not entered");
  a_addr_exit: assert property (
    s_op(`SFD_OP_ADDR4_EXIT) |=> !addr4_o)
    else $error("four byte mode not left");
  a_write_refused: assert property (
    (state == SFD_S_OPCODE) && ev && op_write && !wel_o
      |=> cmd_drop_o && !cmd_valid_o && (state == SFD_S_DROP))
    else $error("unlatched write not refused");
  a_read_request: assert property (
    s_cmd(SFD_K_FAST_READ) |-> rsp_req_o ##1 (state == SFD_S_RESP))
    else $error("fast read gives no response request");

endmodule

// ---- testbench/sfd_host.sv ----
// Host serial controller model driving chip select and link clock
`timescale 1ns/1ps

module sfd_host
(
  output logic serial_clock_o,
  output logic cs_n_o,
  output logic mosi_o,
  input  logic miso_i
);
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];

  // ============================================================
  // Idle levels: clock low, chip select high
  initial
  begin
    serial_clock_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame, mode 0, MSB first; half sets the link rate
  task automatic frame(input realtime half);
    logic [7:0] rx;
    rx_q.delete();
    cs_n_o = 1'b0;
    foreach (tx_q[i])
    begin
      for (int b = 7; b >= 0; b--)
      begin
        mosi_o = tx_q[i][b];
        #half;
        serial_clock_o = 1'b1;
        rx[b] = miso_i;
        #half;
        serial_clock_o = 1'b0;
      end
      rx_q.push_back(rx);
    end
    #half;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line must not hold its value
    tx_q.delete();
    #20;
  endtask
endmodule

// ---- testbench/tb_sfd_decode.sv ----
// Self-checking bench of the serial flash command decoder
`timescale 1ns/1ps
`include "sfd_map.svh"

module tb_sfd_decode
  import sfd_pkg::*;
;
  localparam logic [7:0] RSP = 8'hA5;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       sclk, cs_n, mosi, miso_w, miso_o, miso_oe_o;
  logic       cmd_valid_o, cmd_drop_o, frame_end_o, wel_o, addr4_o;
  sfd_cmd_t   cmd_o, last_cmd;
  logic       prog_valid_o, prog_overflow_o, rsp_req_o;
  logic [7:0] prog_data_o;
  logic       prog_ready_i = 1'b1;
  logic       rsp_valid_i  = 1'b0;
  logic [7:0] rsp_data_i   = RSP;
  logic       oe_seen      = 1'b0;
  logic [7:0] prog_q [$];
  int         failures = 0;
  int         cmp_count = 0;
  int         n_cmd = 0, n_drop = 0, n_fe = 0, c0, d0;
  logic [7:0] op4 [4] = '{`SFD_OP_ECC_READ, `SFD_OP_NORM_READ_WIDE,
                          `SFD_OP_ERASE_CHECK, `SFD_OP_ERASE_COUNT};
  sfd_kind_t  k4 [4] = '{SFD_K_ECC_READ, SFD_K_NORM_READ,
                         SFD_K_ERASE_CHECK, SFD_K_ERASE_COUNT};
  logic [7:0] ope [4] = '{`SFD_OP_SMALL_ERASE, `SFD_OP_LARGE_ERASE,
                          `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B};
  sfd_kind_t  ke [4] = '{SFD_K_SMALL_ERASE, SFD_K_LARGE_ERASE,
                         SFD_K_CHIP_ERASE, SFD_K_CHIP_ERASE};
  int         ne [4] = '{4, 4, 0, 0};

  always #2 clk_i = ~clk_i;

  sfd_host sfd_host_i (.serial_clock_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
                       .miso_i(miso_w));

  sfd_decode #(.FIFO_DEPTH(32)) sfd_decode_i (
    .clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_drop_o(cmd_drop_o),
    .frame_end_o(frame_end_o), .wel_o(wel_o), .addr4_o(addr4_o),
    .prog_valid_o(prog_valid_o), .prog_data_o(prog_data_o),
    .prog_ready_i(prog_ready_i), .prog_overflow_o(prog_overflow_o),
    .rsp_req_o(rsp_req_o), .rsp_valid_i(rsp_valid_i),
    .rsp_data_i(rsp_data_i));

  // Wire level of the data output: released line shows the inverse bit
  assign miso_w = miso_oe_o ? miso_o : ~miso_o;

  // Monitor on the falling edge, where outputs are settled
  always @(negedge clk_i)
  begin
    n_cmd += int'(cmd_valid_o === 1'b1);
    n_drop += int'(cmd_drop_o === 1'b1);
    n_fe += int'(frame_end_o === 1'b1);
    if (cmd_valid_o === 1'b1) last_cmd = cmd_o;
    if (miso_oe_o === 1'b1) oe_seen = 1'b1;
    if (prog_valid_o === 1'b1 && prog_ready_i === 1'b1)
      prog_q.push_back(prog_data_o);
  end

  // Array side answers each response request in the same cycle, 1 ns after the clock edge
  always @(posedge clk_i)
  begin
    #1;
    rsp_valid_i = rsp_req_o;
  end

  // ============================================================
  // Compare and report tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t value %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_cmd(input sfd_kind_t k, input logic w,
                         input logic [31:0] a, input logic [31:0] e);
    sfd_cmd_t exp;
    exp = '{k, w, a, e};
    chk_val(n_cmd - c0, 1);
    cmp_count++;
    if (last_cmd !== exp)
    begin
      failures++;
      $display("BAD %0t command %0h expected %0h", $time, last_cmd, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One frame: opcode, address MSB first, counted data bytes
  task automatic run(input logic [7:0] op, input int nad,
                     input logic [63:0] a, input int nd,
                     input realtime half = 7.5);
    int f0;
    c0 = n_cmd;
    d0 = n_drop;
    f0 = n_fe;
    sfd_host_i.tx_q.push_back(op);
    for (int i = nad - 1; i >= 0; i--)
      sfd_host_i.tx_q.push_back(a[8*i +: 8]);
    for (int i = 0; i < nd; i++)
      sfd_host_i.tx_q.push_back(8'(i));
    sfd_host_i.frame(half);
    repeat (10) @(posedge clk_i);
    #1;
    chk_val(n_fe - f0, 1);
  endtask

  // ============================================================
  // Test sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk_val(wel_o, 0);
    chk_val(addr4_o, 0);
    for (int i = 0; i < 4; i++)
    begin
      run(op4[i], 4, 64'h12345678 + i, 0, 10.0);
      chk_cmd(k4[i], 1'b1, 32'h12345678 + i, 0);
    end
    for (int m = 0; m < 2; m++)
    begin
      run(m ? `SFD_OP_ADDR4_EXIT : `SFD_OP_ADDR4_ENTER, 0, 0, 0);
      chk_val(addr4_o, 32'(!m));
      run(`SFD_OP_NORM_READ, 4 - m, 64'hA1B2C3D4, 0, 10.0);
      chk_cmd(SFD_K_NORM_READ, !m, m ? 32'hB2C3D4 : 32'hA1B2C3D4, 0);
      run(`SFD_OP_FAST_READ, 4 - m, 64'hA1B2C3D4, 0);
      chk_cmd(SFD_K_FAST_READ, !m, m ? 32'hB2C3D4 : 32'hA1B2C3D4, 0);
    end
    run(`SFD_OP_RANGE_CHECK, 8, 64'h00010000_0001FFFF, 0);
    chk_cmd(SFD_K_RANGE_CHECK, 0, 32'h00010000, 32'h0001FFFF);
    run(`SFD_OP_ECC_CLEAR, 0, 0, 0);
    chk_cmd(SFD_K_ECC_CLEAR, 0, 0, 0);
    // Unknown opcode: whole frame ignored, neither issued nor refused
    run(8'hFF, 4, 64'h00000001, 0);
    chk_val(n_cmd - c0, 0);
    chk_val(n_drop - d0, 0);
    for (int i = 0; i < 4; i++)
    begin
      run(ope[i], ne[i], 64'h00040000, 0);
      chk_val(n_drop - d0, 1);
      chk_val(n_cmd - c0, 0);
      run(`SFD_OP_WRITE_LATCH_SET, 0, 0, 0);
      chk_val(wel_o, 1);
      run(ope[i], ne[i], 64'h00040000, 0);
      chk_cmd(ke[i], ne[i] == 4, ne[i] == 4 ? 32'h40000 : 0, 0);
      chk_val(wel_o, 0);
    end
    // Program stream with the far side stalled until overflow
    run(`SFD_OP_WRITE_LATCH_SET, 0, 0, 0);
    prog_ready_i = 1'b0;
    run(`SFD_OP_PAGE_PROG, 4, 64'h00000100, 36);
    chk_cmd(SFD_K_PAGE_PROG, 1, 32'h100, 0);
    chk_val(prog_overflow_o, 1);
    prog_ready_i = 1'b1;
    repeat (50) @(posedge clk_i);
    #1;
    chk_val(prog_q.size(), 33);
    foreach (prog_q[i]) chk_val(prog_q[i], i);
    // Status read answered at two link rates
    for (int s = 0; s < 2; s++)
    begin
      oe_seen = 1'b0;
      run(`SFD_OP_ECC_READ, 4, 64'h200, 3, s ? 20.0 : 7.5);
      chk_val(sfd_host_i.rx_q[6], RSP);
      chk_val(oe_seen, 1);
      chk_val(miso_oe_o, 0);
    end
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule
